// ===== msfr_consts.vh
`ifndef MSFR_CONSTS_VH
`define MSFR_CONSTS_VH
// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define MSFR_A_P0    8'h80
`define MSFR_A_SP    8'h81
`define MSFR_A_DPL0  8'h82
`define MSFR_A_DPH0  8'h83
`define MSFR_A_POINTER1_LOW  8'h84
`define MSFR_A_POINTER1_HIGH  8'h85
`define MSFR_A_POWER_SPEED_CONTROL  8'h87
`define MSFR_A_TIMER_CONTROL  8'h88
`define MSFR_A_TIMER_MODE  8'h89
`define MSFR_A_TL0   8'h8a
`define MSFR_A_TL1   8'h8b
`define MSFR_A_TH0   8'h8c
`define MSFR_A_TH1   8'h8d
`define MSFR_A_STR   8'h8e
`define MSFR_A_P1    8'h90
`define MSFR_A_PORT1_DIRECTION  8'h91
`define MSFR_A_PSEL  8'h92
`define MSFR_A_S0CT  8'h98
`define MSFR_A_S0BF  8'h99
`define MSFR_A_IE2   8'h9a
`define MSFR_A_S1CT  8'h9b
`define MSFR_A_S1BF  8'h9c
`define MSFR_A_S1RL  8'h9d
`define MSFR_A_P2    8'ha0
`define MSFR_A_PORT2_DIRECTION  8'ha1
`define MSFR_A_PORT0_DIRECTION  8'ha2
`define MSFR_A_IE0   8'ha8
`define MSFR_A_IP0   8'ha9
`define MSFR_A_S0RL  8'haa
`define MSFR_A_P3    8'hb0
`define MSFR_A_IE1   8'hb8
`define MSFR_A_IP1   8'hb9
`define MSFR_A_S0RH  8'hba
`define MSFR_A_S1RH  8'hbb
`define MSFR_A_PAGE  8'hbf
`define MSFR_A_IRC   8'hc0
`define MSFR_A_XPOL  8'hc8
`define MSFR_A_PSW   8'hd0
`define MSFR_A_BAUD  8'hd8
`define MSFR_A_ACC   8'he0
`define MSFR_A_AUX   8'hf0
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MSFR_R_PORT  8'hff
`define MSFR_R_SP    8'h07
`define MSFR_R_STR   8'h01
`define MSFR_R_S0RL  8'hd9
`define MSFR_R_RLH   8'h03
`define MSFR_R_ZERO  8'h00
`define MSFR_R_PC    16'h0000
`define MSFR_R_DIR   8'h00
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MSFR_PSW_CY   7
`define MSFR_PSW_AC   6
`define MSFR_PSW_F0   5
`define MSFR_PSW_RS1  4
`define MSFR_PSW_RS0  3
`define MSFR_PSW_OV   2
`define MSFR_PSW_F1   1
`define MSFR_PSW_P    0
`define MSFR_BAUD_BIT 7
`define MSFR_PSEL_BIT 0
`define MSFR_XPOL_I2  5
`define MSFR_XPOL_I3  6
`define MSFR_BANK_SH  3
`define MSFR_UNDEF    8'h00
`define MSFR_ONE8     8'h01
`define MSFR_ONE16    16'h0001
`endif

// ===== msfr_port.v
`default_nettype none
`include "msfr_consts.vh"
module msfr_port #(
  parameter W = 8
) (
  input  wire         i_clk,
  input  wire         i_rstn,
  input  wire         i_wr_latch,
  input  wire         i_wr_dir,
  input  wire [W-1:0] i_wdata,
  input  wire [W-1:0] i_pin,
  output reg  [W-1:0] o_latch,
  output reg  [W-1:0] o_dir,
  output reg  [W-1:0] o_pin_sample
);
  // ----------------------------------------------------------------
  // Latch and direction, one bit slice per pin
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge i_clk) begin
        if (!i_rstn) begin
          o_latch[g]      <= 1'b1;
          o_dir[g]        <= 1'b0;
          o_pin_sample[g] <= 1'b1;
        end else begin
          if (i_wr_latch)
            o_latch[g] <= i_wdata[g];
          if (i_wr_dir)
            o_dir[g] <= i_wdata[g];
          // Pin level, not latch, so driven pulses are observable
          o_pin_sample[g] <= i_pin[g];
        end
      end
    end
  endgenerate
endmodule // msfr_port
`default_nettype wire

// ===== msfr_bank.v
`default_nettype none
`include "msfr_consts.vh"
module msfr_bank (
  input  wire        i_clk,
  input  wire        i_rstn,
  // Special register access from the core
  input  wire        i_sfr_wr,
  input  wire        i_sfr_rd,
  input  wire [7:0]  i_sfr_addr,
  input  wire [7:0]  i_sfr_wdata,
  output reg  [7:0]  o_sfr_rdata,
  // Core execution events
  input  wire        i_fetch,
  input  wire        i_pc_load,
  input  wire [15:0] i_pc_target,
  input  wire        i_push,
  input  wire        i_pop,
  input  wire        i_acc_wr,
  input  wire [7:0]  i_acc_wdata,
  input  wire        i_aux_wr,
  input  wire [7:0]  i_aux_wdata,
  input  wire        i_flags_wr,
  input  wire [3:0]  i_flags_wdata,
  input  wire        i_ptr_wr,
  input  wire [15:0] i_ptr_wdata,
  // Digital pins, three ports
  input  wire [7:0]  i_digital_io_pin0,
  input  wire [7:0]  i_digital_io_pin1,
  input  wire [7:0]  i_digital_io_pin2,
  output reg  [7:0]  o_digital_io_pin0,
  output reg  [7:0]  o_digital_io_pin1,
  output reg  [7:0]  o_digital_io_pin2,
  output reg  [7:0]  o_digital_io_oe0,
  output reg  [7:0]  o_digital_io_oe1,
  output reg  [7:0]  o_digital_io_oe2,
  // Core-facing state
  output reg  [15:0] o_pc,
  output reg  [7:0]  o_stack_addr,
  output reg  [7:0]  o_accumulator,
  output reg  [7:0]  o_aux,
  output reg  [15:0] o_active_pointer,
  output reg  [7:0]  o_paged_address_high,
  output reg  [4:0]  o_bank_base,
  output reg  [7:0]  o_psw,
  output reg         o_baud_double,
  output reg  [1:0]  o_ext_irq_pol
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [7:0]  sp_r;
  reg  [15:0] pc_r;
  reg  [7:0]  ptr_lo_r [0:1];
  reg  [7:0]  ptr_hi_r [0:1];
  reg         psel_r;
  reg  [7:0]  acc_r;
  reg  [7:0]  aux_r;
  reg  [7:0]  psw_r;
  reg  [7:0]  page_r;
  reg         baud_r;
  reg  [7:0]  xpol_r;
  reg  [7:0]  power_speed_control_r, timer_control_r, timer_mode_r, tl0_r, tl1_r, th0_r, th1_r, str_r;
  reg  [7:0]  s0ct_r, s0bf_r, ie2_r, s1ct_r, s1bf_r, s1rl_r;
  reg  [7:0]  ie0_r, ip0_r, s0rl_r, ie1_r, ip1_r, s0rh_r, s1rh_r, irc_r;
  reg  [7:0]  p3_r;
  reg  [7:0]  rdata_nxt;
  reg  [15:0] pc_nxt;
  reg  [7:0]  sp_nxt;
  wire        parity_w;
  wire [7:0]  p0_l, p1_l, p2_l, d0_l, d1_l, d2_l, s0_l, s1_l, s2_l;

  wire wr_p0 = i_sfr_wr && (i_sfr_addr == `MSFR_A_P0);
  wire wr_p1 = i_sfr_wr && (i_sfr_addr == `MSFR_A_P1);
  wire wr_p2 = i_sfr_wr && (i_sfr_addr == `MSFR_A_P2);
  wire wr_d0 = i_sfr_wr && (i_sfr_addr == `MSFR_A_PORT0_DIRECTION);
  wire wr_d1 = i_sfr_wr && (i_sfr_addr == `MSFR_A_PORT1_DIRECTION);
  wire wr_d2 = i_sfr_wr && (i_sfr_addr == `MSFR_A_PORT2_DIRECTION);

  // ----------------------------------------------------------------
  // Port slices
  // ----------------------------------------------------------------
  msfr_port #(.W(8)) u_port0 (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_wr_latch(wr_p0), .i_wr_dir(wr_d0),
    .i_wdata(i_sfr_wdata), .i_pin(i_digital_io_pin0),
    .o_latch(p0_l), .o_dir(d0_l), .o_pin_sample(s0_l));
  msfr_port #(.W(8)) u_port1 (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_wr_latch(wr_p1), .i_wr_dir(wr_d1),
    .i_wdata(i_sfr_wdata), .i_pin(i_digital_io_pin1),
    .o_latch(p1_l), .o_dir(d1_l), .o_pin_sample(s1_l));
  msfr_port #(.W(8)) u_port2 (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_wr_latch(wr_p2), .i_wr_dir(wr_d2),
    .i_wdata(i_sfr_wdata), .i_pin(i_digital_io_pin2),
    .o_latch(p2_l), .o_dir(d2_l), .o_pin_sample(s2_l));

  // Even parity: bit set when the accumulator holds an odd count of ones
  assign parity_w = ^acc_r;

  // ----------------------------------------------------------------
  // Program counter and stack pointer next values
  // ----------------------------------------------------------------
  always @* begin
    pc_nxt = pc_r;
    if (i_pc_load)
      pc_nxt = i_pc_target;
    else if (i_fetch)
      pc_nxt = pc_r + `MSFR_ONE16;
    sp_nxt = sp_r;
    // Pre-increment: the first pushed byte lands one above reset value
    if (i_push)
      sp_nxt = sp_r + `MSFR_ONE8;
    else if (i_pop)
      sp_nxt = sp_r - `MSFR_ONE8;
  end

  // ----------------------------------------------------------------
  // Register writes; core events win over a software write in the same cycle
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      sp_r        <= `MSFR_R_SP;
      pc_r        <= `MSFR_R_PC;
      ptr_lo_r[0] <= `MSFR_R_ZERO;
      ptr_hi_r[0] <= `MSFR_R_ZERO;
      ptr_lo_r[1] <= `MSFR_R_ZERO;
      ptr_hi_r[1] <= `MSFR_R_ZERO;
      psel_r      <= 1'b0;
      acc_r       <= `MSFR_R_ZERO;
      aux_r       <= `MSFR_R_ZERO;
      psw_r       <= `MSFR_R_ZERO;
      page_r      <= `MSFR_R_ZERO;
      baud_r      <= 1'b0;
      xpol_r      <= `MSFR_R_ZERO;
      power_speed_control_r <= `MSFR_R_ZERO; timer_control_r <= `MSFR_R_ZERO; timer_mode_r <= `MSFR_R_ZERO;
      tl0_r  <= `MSFR_R_ZERO; tl1_r  <= `MSFR_R_ZERO; th0_r  <= `MSFR_R_ZERO;
      th1_r  <= `MSFR_R_ZERO; str_r  <= `MSFR_R_STR;  s0ct_r <= `MSFR_R_ZERO;
      s0bf_r <= `MSFR_R_ZERO; ie2_r  <= `MSFR_R_ZERO; s1ct_r <= `MSFR_R_ZERO;
      s1bf_r <= `MSFR_R_ZERO; s1rl_r <= `MSFR_R_ZERO; ie0_r  <= `MSFR_R_ZERO;
      ip0_r  <= `MSFR_R_ZERO; s0rl_r <= `MSFR_R_S0RL; ie1_r  <= `MSFR_R_ZERO;
      ip1_r  <= `MSFR_R_ZERO; s0rh_r <= `MSFR_R_RLH;  s1rh_r <= `MSFR_R_RLH;
      irc_r  <= `MSFR_R_ZERO; p3_r   <= `MSFR_R_PORT;
    end else begin
      pc_r <= pc_nxt;
      if (i_sfr_wr) begin
        case (i_sfr_addr)
          `MSFR_A_SP:   sp_r        <= i_sfr_wdata;
          `MSFR_A_DPL0: ptr_lo_r[0] <= i_sfr_wdata;
          `MSFR_A_DPH0: ptr_hi_r[0] <= i_sfr_wdata;
          `MSFR_A_POINTER1_LOW: ptr_lo_r[1] <= i_sfr_wdata;
          `MSFR_A_POINTER1_HIGH: ptr_hi_r[1] <= i_sfr_wdata;
          `MSFR_A_PSEL: psel_r      <= i_sfr_wdata[`MSFR_PSEL_BIT];
          `MSFR_A_ACC:  acc_r       <= i_sfr_wdata;
          `MSFR_A_AUX:  aux_r       <= i_sfr_wdata;
          `MSFR_A_PSW:  psw_r       <= i_sfr_wdata;
          `MSFR_A_PAGE: page_r      <= i_sfr_wdata;
          `MSFR_A_BAUD: baud_r      <= i_sfr_wdata[`MSFR_BAUD_BIT];
          `MSFR_A_XPOL: xpol_r      <= i_sfr_wdata;
          `MSFR_A_POWER_SPEED_CONTROL: power_speed_control_r <= i_sfr_wdata;
          `MSFR_A_TIMER_CONTROL: timer_control_r <= i_sfr_wdata;
          `MSFR_A_TIMER_MODE: timer_mode_r <= i_sfr_wdata;
          `MSFR_A_TL0:  tl0_r  <= i_sfr_wdata;
          `MSFR_A_TL1:  tl1_r  <= i_sfr_wdata;
          `MSFR_A_TH0:  th0_r  <= i_sfr_wdata;
          `MSFR_A_TH1:  th1_r  <= i_sfr_wdata;
          `MSFR_A_STR:  str_r  <= i_sfr_wdata;
          `MSFR_A_S0CT: s0ct_r <= i_sfr_wdata;
          `MSFR_A_S0BF: s0bf_r <= i_sfr_wdata;
          `MSFR_A_IE2:  ie2_r  <= i_sfr_wdata;
          `MSFR_A_S1CT: s1ct_r <= i_sfr_wdata;
          `MSFR_A_S1BF: s1bf_r <= i_sfr_wdata;
          `MSFR_A_S1RL: s1rl_r <= i_sfr_wdata;
          `MSFR_A_IE0:  ie0_r  <= i_sfr_wdata;
          `MSFR_A_IP0:  ip0_r  <= i_sfr_wdata;
          `MSFR_A_S0RL: s0rl_r <= i_sfr_wdata;
          `MSFR_A_IE1:  ie1_r  <= i_sfr_wdata;
          `MSFR_A_IP1:  ip1_r  <= i_sfr_wdata;
          `MSFR_A_S0RH: s0rh_r <= i_sfr_wdata;
          `MSFR_A_S1RH: s1rh_r <= i_sfr_wdata;
          `MSFR_A_IRC:  irc_r  <= i_sfr_wdata;
          `MSFR_A_P3:   p3_r   <= i_sfr_wdata;
          default: ; // Unmapped writes are dropped
        endcase
      end
      // Core datapath updates take priority over a same-cycle register write
      if (i_push || i_pop)
        sp_r <= sp_nxt;
      if (i_acc_wr)
        acc_r <= i_acc_wdata;
      if (i_aux_wr)
        aux_r <= i_aux_wdata;
      if (i_flags_wr) begin
        psw_r[`MSFR_PSW_CY] <= i_flags_wdata[3];
        psw_r[`MSFR_PSW_AC] <= i_flags_wdata[2];
        psw_r[`MSFR_PSW_OV] <= i_flags_wdata[1];
        psw_r[`MSFR_PSW_F1] <= i_flags_wdata[0];
      end
      // Only the active pointer is touched; the other keeps its value
      if (i_ptr_wr) begin
        ptr_lo_r[psel_r] <= i_ptr_wdata[7:0];
        ptr_hi_r[psel_r] <= i_ptr_wdata[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    case (i_sfr_addr)
      `MSFR_A_P0:   rdata_nxt = s0_l;
      `MSFR_A_P1:   rdata_nxt = s1_l;
      `MSFR_A_P2:   rdata_nxt = s2_l;
      `MSFR_A_PORT0_DIRECTION: rdata_nxt = d0_l;
      `MSFR_A_PORT1_DIRECTION: rdata_nxt = d1_l;
      `MSFR_A_PORT2_DIRECTION: rdata_nxt = d2_l;
      `MSFR_A_SP:   rdata_nxt = sp_r;
      `MSFR_A_DPL0: rdata_nxt = ptr_lo_r[0];
      `MSFR_A_DPH0: rdata_nxt = ptr_hi_r[0];
      `MSFR_A_POINTER1_LOW: rdata_nxt = ptr_lo_r[1];
      `MSFR_A_POINTER1_HIGH: rdata_nxt = ptr_hi_r[1];
      `MSFR_A_PSEL: rdata_nxt = {7'h00, psel_r};
      `MSFR_A_ACC:  rdata_nxt = acc_r;
      `MSFR_A_AUX:  rdata_nxt = aux_r;
      `MSFR_A_PSW:  rdata_nxt = {psw_r[7:1], parity_w};
      `MSFR_A_PAGE: rdata_nxt = page_r;
      `MSFR_A_BAUD: rdata_nxt = {baud_r, 7'h00};
      `MSFR_A_XPOL: rdata_nxt = xpol_r;
      `MSFR_A_POWER_SPEED_CONTROL: rdata_nxt = power_speed_control_r;
      `MSFR_A_TIMER_CONTROL: rdata_nxt = timer_control_r;
      `MSFR_A_TIMER_MODE: rdata_nxt = timer_mode_r;
      `MSFR_A_TL0:  rdata_nxt = tl0_r;
      `MSFR_A_TL1:  rdata_nxt = tl1_r;
      `MSFR_A_TH0:  rdata_nxt = th0_r;
      `MSFR_A_TH1:  rdata_nxt = th1_r;
      `MSFR_A_STR:  rdata_nxt = str_r;
      `MSFR_A_S0CT: rdata_nxt = s0ct_r;
      `MSFR_A_S0BF: rdata_nxt = s0bf_r;
      `MSFR_A_IE2:  rdata_nxt = ie2_r;
      `MSFR_A_S1CT: rdata_nxt = s1ct_r;
      `MSFR_A_S1BF: rdata_nxt = s1bf_r;
      `MSFR_A_S1RL: rdata_nxt = s1rl_r;
      `MSFR_A_IE0:  rdata_nxt = ie0_r;
      `MSFR_A_IP0:  rdata_nxt = ip0_r;
      `MSFR_A_S0RL: rdata_nxt = s0rl_r;
      `MSFR_A_IE1:  rdata_nxt = ie1_r;
      `MSFR_A_IP1:  rdata_nxt = ip1_r;
      `MSFR_A_S0RH: rdata_nxt = s0rh_r;
      `MSFR_A_S1RH: rdata_nxt = s1rh_r;
      `MSFR_A_IRC:  rdata_nxt = irc_r;
      `MSFR_A_P3:   rdata_nxt = p3_r;
      default:      rdata_nxt = `MSFR_UNDEF;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered outputs; read data holds between reads
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_sfr_rdata          <= `MSFR_R_ZERO;
      o_digital_io_pin0    <= `MSFR_R_PORT;
      o_digital_io_pin1    <= `MSFR_R_PORT;
      o_digital_io_pin2    <= `MSFR_R_PORT;
      o_digital_io_oe0     <= `MSFR_R_DIR;
      o_digital_io_oe1     <= `MSFR_R_DIR;
      o_digital_io_oe2     <= `MSFR_R_DIR;
      o_pc                 <= `MSFR_R_PC;
      o_stack_addr         <= `MSFR_R_SP;
      o_accumulator        <= `MSFR_R_ZERO;
      o_aux                <= `MSFR_R_ZERO;
      o_active_pointer     <= {`MSFR_R_ZERO, `MSFR_R_ZERO};
      o_paged_address_high <= `MSFR_R_ZERO;
      o_bank_base          <= 5'h00;
      o_psw                <= `MSFR_R_ZERO;
      o_baud_double        <= 1'b0;
      o_ext_irq_pol        <= 2'h0;
    end else begin
      if (i_sfr_rd)
        o_sfr_rdata <= rdata_nxt;
      o_digital_io_pin0    <= p0_l;
      o_digital_io_pin1    <= p1_l;
      o_digital_io_pin2    <= p2_l;
      o_digital_io_oe0     <= d0_l;
      o_digital_io_oe1     <= d1_l;
      o_digital_io_oe2     <= d2_l;
      o_pc                 <= pc_r;
      o_stack_addr         <= sp_r;
      o_accumulator        <= acc_r;
      o_aux                <= aux_r;
      o_active_pointer     <= {ptr_hi_r[psel_r], ptr_lo_r[psel_r]};
      o_paged_address_high <= page_r;
      // Bank base = bank number times eight
      o_bank_base <= {psw_r[`MSFR_PSW_RS1:`MSFR_PSW_RS0], 3'h0};
      o_psw                <= {psw_r[7:1], parity_w};
      o_baud_double        <= baud_r;
      o_ext_irq_pol        <= {xpol_r[`MSFR_XPOL_I3], xpol_r[`MSFR_XPOL_I2]};
    end
  end
endmodule // msfr_bank
`default_nettype wire

// ===== msfr_bank_asserts.sv
`default_nettype none
module msfr_chk (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_sfr_wr,
  input wire logic        i_sfr_rd,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic        i_fetch,
  input wire logic        i_pc_load,
  input wire logic [15:0] i_pc_target,
  input wire logic        i_push,
  input wire logic        i_acc_wr,
  input wire logic [7:0]  i_acc_wdata,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic [7:0]  o_digital_io_oe0,
  input wire logic [15:0] o_pc,
  input wire logic [7:0]  o_stack_addr,
  input wire logic [7:0]  o_accumulator,
  input wire logic [4:0]  o_bank_base,
  input wire logic [7:0]  o_psw,
  input wire logic        o_baud_double
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Properties; state outputs trail their register by one cycle
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  reset_vals_a: assert property (
    $rose(i_rstn) |-> o_stack_addr == 8'h07 && o_pc == 16'h0000 && o_digital_io_oe0 == 8'h00)
    else $error("reset state wrong");
  stack_push_a: assert property (
    i_push |-> ##2 o_stack_addr == $past(o_stack_addr) + 8'h01)
    else $error("stack pointer did not step up on push");
  pc_fetch_a: assert property (
    i_fetch && !i_pc_load |-> ##2 o_pc == $past(o_pc) + 16'h0001)
    else $error("program counter did not advance");
  pc_load_a: assert property (
    i_pc_load |-> ##2 o_pc == $past(i_pc_target, 2))
    else $error("program counter load lost");
  bank_map_a: assert property (
    o_bank_base == {o_psw[4:3], 3'b000})
    else $error("bank base does not follow bank bits");
  parity_hw_a: assert property (
    o_psw[0] == ^o_accumulator)
    else $error("parity flag wrong");
  acc_load_a: assert property (
    i_acc_wr |-> ##2 o_accumulator == $past(i_acc_wdata, 2))
    else $error("accumulator load lost");
  dir_drive_a: assert property (
    i_sfr_wr && i_sfr_addr == 8'ha2 |-> ##2 o_digital_io_oe0 == $past(i_sfr_wdata, 2))
    else $error("direction write not on enables");
  baud_bit_a: assert property (
    i_sfr_wr && i_sfr_addr == 8'hd8 |-> ##2 o_baud_double == $past(i_sfr_wdata[7], 2))
    else $error("baud bit not taken from bit 7");
  unmapped_rd_a: assert property (
    i_sfr_rd && i_sfr_addr == 8'h86 |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  push_seen_c: cover property (i_push ##1 !i_push);
  load_fetch_c: cover property (i_pc_load && i_fetch);
  psw_read_c: cover property (i_sfr_rd && i_sfr_addr == 8'hd0);
endmodule // msfr_chk
bind msfr_bank msfr_chk u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_sfr_wr(i_sfr_wr),
  .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .i_fetch(i_fetch),
  .i_pc_load(i_pc_load), .i_pc_target(i_pc_target), .i_push(i_push), .i_acc_wr(i_acc_wr),
  .i_acc_wdata(i_acc_wdata), .o_sfr_rdata(o_sfr_rdata), .o_digital_io_oe0(o_digital_io_oe0),
  .o_pc(o_pc), .o_stack_addr(o_stack_addr), .o_accumulator(o_accumulator),
  .o_bank_base(o_bank_base), .o_psw(o_psw), .o_baud_double(o_baud_double));
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus, outputs and pin model
  // ----------------------------------------------------------------
  logic        i_clk = 1'b0, i_rstn = 1'b0, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
  logic [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_acc_wdata = 8'h00;
  logic [7:0]  i_aux_wdata = 8'h00;
  logic        i_fetch = 1'b0, i_pc_load = 1'b0, i_push = 1'b0, i_pop = 1'b0;
  logic        i_acc_wr = 1'b0, i_aux_wr = 1'b0, i_flags_wr = 1'b0, i_ptr_wr = 1'b0;
  logic [3:0]  i_flags_wdata = 4'h0;
  logic [15:0] i_pc_target = 16'h0000, i_ptr_wdata = 16'h0000;
  logic [23:0] ext = 24'h000000;
  wire  [7:0]  i_digital_io_pin0, i_digital_io_pin1, i_digital_io_pin2;
  wire  [7:0]  o_digital_io_pin0, o_digital_io_pin1, o_digital_io_pin2;
  wire  [7:0]  o_digital_io_oe0, o_digital_io_oe1, o_digital_io_oe2;
  wire  [7:0]  o_sfr_rdata, o_stack_addr, o_accumulator, o_aux, o_paged_address_high, o_psw;
  wire  [15:0] o_pc, o_active_pointer;
  wire  [4:0]  o_bank_base;
  wire         o_baud_double;
  wire  [1:0]  o_ext_irq_pol;
  wire  [23:0] pin_out = {o_digital_io_pin2, o_digital_io_pin1, o_digital_io_pin0};
  wire  [23:0] pin_oe = {o_digital_io_oe2, o_digital_io_oe1, o_digital_io_oe0};
  // Driven pins read back the latch, released pins the outside level
  assign {i_digital_io_pin2, i_digital_io_pin1, i_digital_io_pin0} =
    (pin_oe & pin_out) | (~pin_oe & ext);
  int          failures = 0, comparisons = 0, seed = 58;
  logic        rd_seen = 1'b0;
  logic [7:0]  exp_q[$], addr_q[$];
  localparam logic [7:0] RA [0:37] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h87, 8'h88,
    8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h91, 8'h92, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c,
    8'h9d, 8'ha1, 8'ha2, 8'ha8, 8'ha9, 8'haa, 8'hb0, 8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbf, 8'hc0,
    8'hc8, 8'hd0, 8'hd8, 8'he0, 8'hf0};
  localparam logic [7:0] RV [0:37] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hd9, 8'hff, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] LA [0:2] = '{8'h80, 8'h90, 8'ha0};
  localparam logic [7:0] DA [0:2] = '{8'ha2, 8'h91, 8'ha1};

  msfr_bank dut (.i_clk, .i_rstn, .i_sfr_wr, .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata,
    .i_fetch, .i_pc_load, .i_pc_target, .i_push, .i_pop, .i_acc_wr, .i_acc_wdata, .i_aux_wr,
    .i_aux_wdata, .i_flags_wr, .i_flags_wdata, .i_ptr_wr, .i_ptr_wdata, .i_digital_io_pin0,
    .i_digital_io_pin1, .i_digital_io_pin2, .o_digital_io_pin0, .o_digital_io_pin1,
    .o_digital_io_pin2, .o_digital_io_oe0, .o_digital_io_oe1, .o_digital_io_oe2, .o_pc,
    .o_stack_addr, .o_accumulator, .o_aux, .o_active_pointer, .o_paged_address_high,
    .o_bank_base, .o_psw, .o_baud_double, .o_ext_irq_pol);

  always #2.5 i_clk = ~i_clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One edge with the register strobes dropped
  task automatic step;
    @(posedge i_clk);
    {i_sfr_wr, i_sfr_rd} <= 2'b00;
  endtask
  task automatic settle;
    step;
    {i_fetch, i_pc_load, i_push, i_pop, i_acc_wr, i_aux_wr, i_flags_wr, i_ptr_wr} <= 8'h00;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {i_sfr_wr, i_sfr_rd} <= 2'b10;
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
  endtask
  // Reads note the expected byte; the monitor compares a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    {i_sfr_wr, i_sfr_rd} <= 2'b01;
    i_sfr_addr <= a;
    exp_q.push_back(e);
    addr_q.push_back(a);
  endtask
  // ----------------------------------------------------------------
  // Read data monitor
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (rd_seen && exp_q.size() != 0)
      chk($sformatf("read %h", addr_q.pop_front()), exp_q.pop_front(), o_sfr_rdata);
    rd_seen <= i_sfr_rd & i_rstn;
  end
  // Hang guard
  initial begin : guard
    repeat (20000) @(posedge i_clk);
    failures++;
    close_out;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : main
    int i;
    logic [7:0] d;
    logic [31:0] r;
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    ext <= $random(seed);
    #1;
    chk("pins", 24'hffffff, pin_out);
    chk("enables", 24'h000000, pin_oe);
    for (i = 0; i < 38; i++) rd(RA[i], RV[i]);
    settle;
    for (i = 0; i < 3; i++) rd(LA[i], ext[8*i +: 8]);
    for (i = 0; i < 38; i++) begin
      if (!(RA[i] inside {8'h91, 8'ha1, 8'ha2, 8'h92, 8'hc8, 8'hd0, 8'hd8})) begin
        d = $random(seed);
        wr(RA[i], d);
        rd(RA[i], d);
      end
    end
    wr(8'h81, 8'h07);
    step;
    {i_push, i_pop} <= 2'b11;
    settle;
    rd(8'h81, 8'h08);
    wr(8'h81, 8'hff);
    step;
    i_push <= 1'b1;
    settle;
    rd(8'h81, 8'h00);
    step;
    i_pop <= 1'b1;
    settle;
    rd(8'h81, 8'hff);
    step;
    i_fetch <= 1'b1;
    repeat (4) @(posedge i_clk);
    settle;
    chk("pc", 16'h0005, o_pc);
    step;
    {i_fetch, i_pc_load} <= 2'b11;
    i_pc_target <= 16'hffff;
    settle;
    chk("pc", 16'hffff, o_pc);
    step;
    i_fetch <= 1'b1;
    settle;
    chk("pc", 16'h0000, o_pc);
    step;
    {i_acc_wr, i_aux_wr} <= 2'b11;
    i_acc_wdata <= 8'h01;
    i_aux_wdata <= 8'h3c;
    settle;
    chk("acc", 8'h01, o_accumulator);
    chk("aux", 8'h3c, o_aux);
    rd(8'hf0, 8'h3c);
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(8'hd0, (d & 8'he7) | (i << 3));
      settle;
      chk("bank", i * 8, o_bank_base);
      rd(8'hd0, (d & 8'he6) | (i << 3) | 8'h01);
    end
    wr(8'hd0, 8'h00);
    step;
    i_flags_wr <= 1'b1;
    i_flags_wdata <= 4'b1010;
    settle;
    rd(8'hd0, 8'h85);
    r = $random(seed);
    wr(8'h82, r[7:0]);
    wr(8'h83, r[15:8]);
    wr(8'h84, r[23:16]);
    wr(8'h85, r[31:24]);
    wr(8'h92, 8'hff);
    settle;
    chk("pointer", r[31:16], o_active_pointer);
    rd(8'h92, 8'h01);
    step;
    i_ptr_wr <= 1'b1;
    i_ptr_wdata <= 16'hbeef;
    settle;
    rd(8'h84, 8'hef);
    rd(8'h85, 8'hbe);
    rd(8'h82, r[7:0]);
    rd(8'h83, r[15:8]);
    wr(8'h92, 8'h00);
    settle;
    chk("pointer", r[15:0], o_active_pointer);
    for (i = 0; i < 3; i++) begin
      d = $random(seed);
      wr(LA[i], d);
      wr(DA[i], 8'hff);
      settle;
      chk("pins", d, pin_out[8*i +: 8]);
      chk("enables", 8'hff, pin_oe[8*i +: 8]);
      rd(LA[i], d);
      wr(DA[i], 8'h0f);
      settle;
      rd(LA[i], (d & 8'h0f) | (ext[8*i +: 8] & 8'hf0));
    end
    wr(8'h86, 8'h5a);
    rd(8'h86, 8'h00);
    wr(8'hf8, 8'h5a);
    rd(8'hf8, 8'h00);
    wr(8'hd8, 8'hff);
    settle;
    chk("baud", 1'b1, o_baud_double);
    rd(8'hd8, 8'h80);
    wr(8'hc8, 8'h20);
    settle;
    chk("polarity", 2'b01, o_ext_irq_pol);
    wr(8'hc8, 8'h40);
    settle;
    chk("polarity", 2'b10, o_ext_irq_pol);
    d = $random(seed);
    wr(8'hbf, d);
    settle;
    chk("page", d, o_paged_address_high);
    settle;
    chk("pending reads", 24'h000000, exp_q.size());
    close_out;
  end
endmodule // tb_top
`default_nettype wire
